// ---- shared/rtcc_defs.svh ----
// offsets, field positions, reset values and timing counts of the rtc control block
// assumes a 20 MHz system clock and a 32-bit apb with word-aligned registers
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RTCC_IDX_CAPTURE0 6'h00
`define RTCC_IDX_CAPTURE3 6'h03
`define RTCC_IDX_CONTROL 6'h04
`define RTCC_IDX_ALARM0 6'h08
`define RTCC_IDX_ALARM3 6'h0B
`define RTCC_IDX_INT_STATUS 6'h10
`define RTCC_IDX_INT_MASK 6'h11

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RTCC_CTRL_OSC_EN 7
`define RTCC_CTRL_MCD_EN 6
`define RTCC_CTRL_OSC_FAIL 5
`define RTCC_CTRL_RUN 4
`define RTCC_CTRL_ALARM_EN 3
`define RTCC_CTRL_ALARM 2
`define RTCC_CTRL_LOAD 1
`define RTCC_CTRL_SNAP 0
`define RTCC_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// interrupt status and mask fields
// ----------------------------------------------------------------
`define RTCC_INT_ALARM 0
`define RTCC_INT_FAIL 1
`define RTCC_INT_RESET 2'h0
`define RTCC_BYTE_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTCC_CLK_HZ 20000000
`define RTCC_MCD_TIME_US 100
`define RTCC_MCD_CYCLES ((`RTCC_MCD_TIME_US * `RTCC_CLK_HZ) / 1000000)

`endif

// ---- shared/rtcc_pkg.sv ----
// types shared by the rtc control block
// assumes the constants header is included by each design file
package rtcc_pkg;

	typedef logic [31:0] rtcc_word_t;
	typedef logic [7:0] rtcc_byte_t;

	// ----------------------------------------------------------------
	// register select after address decode
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_CAPTURE = 3'b001,
		SEL_CONTROL = 3'b010,
		SEL_ALARM = 3'b011,
		SEL_STATUS = 3'b100,
		SEL_MASK = 3'b101
	} rtcc_sel_e;

endpackage

// ---- rtl/rtcc_timer.sv ----
// 32-bit rtc timer with load and zero on oscillator ticks
// assumes tick is a one-cycle pulse per oscillator cycle
`timescale 1ns/1ps
`include "rtcc_defs.svh"

module rtcc_timer #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic run,
	input wire logic load,
	input wire logic zero,
	input wire logic [WIDTH-1:0] load_value,
	output logic [WIDTH-1:0] count
);

	// load and zero act even when stopped; neither halts counting afterwards
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
		end else if (tick) begin
			if (load) begin
				count <= load_value;
			end else if (zero) begin
				count <= '0;
			end else if (run) begin
				count <= count + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_timer_count_up: assert property (tick && run && !load && !zero |=> count == $past(count) + 1'b1)
		else $error("timer did not advance by one");
	a_timer_hold_stop: assert property ((!tick || (!run && !load && !zero)) |=> $stable(count))
		else $error("timer moved while stopped or idle");

endmodule

// ---- rtl/rtcc_mcd.sv ----
// missing-clock detector on the sampled oscillator level
// assumes osc_level is synchronous to clk
`timescale 1ns/1ps
`include "rtcc_defs.svh"

module rtcc_mcd #(
	parameter int LIMIT = `RTCC_MCD_CYCLES,
	parameter int CW = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic osc_level,
	output logic fail
);

	logic level_prev_reg;
	logic [CW-1:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			level_prev_reg <= 1'b0;
		end else begin
			level_prev_reg <= osc_level;
		end
	end

	// saturates one past the limit so a stall fires only once
	always_ff @(posedge clk) begin
		if (rst || !enable || (osc_level != level_prev_reg)) begin
			cnt_reg <= '0;
		end else if (cnt_reg != CW'(LIMIT + 1)) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign fail = enable && (osc_level == level_prev_reg) && (cnt_reg == CW'(LIMIT));

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_mcd_fire_cause: assert property (fail |-> enable && $stable(osc_level) && $past(cnt_reg) == CW'(LIMIT - 1))
		else $error("missing clock fired without a full stall");

endmodule

// ---- rtl/rtcc_top.sv ----
// rtc control and status register with timer, alarm and missing-clock detector
// assumes apb master on CLOCK and RTC_OSC sampled synchronously to CLOCK
//
// Functional notes
// - bit 7 switches oscillator and bias on
// - bit 6 enables missing-clock detector
// - detector sets sticky oscillator-fail flag bit 5
// - bit 4 runs timer, clear holds count
// - bit 3 enables alarm; disable clears flag
// - reading bit 2 returns alarm flag
// - writing bit 2 sets auto-reset enable
// - bit 1 loads timer, self-clears when done
// - bit 0 snapshots timer, self-clears when done
// - alarm flag lasts one oscillator cycle at most
// - running timer increments every oscillator cycle
// - alarm when timer equals match value
// - auto-reset zeroes timer cycle after alarm
// - detector fires on level stuck over 100us
`timescale 1ns/1ps
`include "rtcc_defs.svh"

module rtcc_top #(
	parameter int MCD_CYCLES = `RTCC_MCD_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RTC_OSC,
	output logic OSC_ENABLE,
	output logic ALARM_EVENT,
	output logic IRQ
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	rtcc_pkg::rtcc_sel_e sel;
	logic [5:0] idx;
	logic wr;
	logic wr_ctrl;
	logic rd_setup;
	logic osc_en_reg;
	logic mcd_en_reg;
	logic fail_reg;
	logic run_reg;
	logic aen_reg;
	logic autorst_reg;
	logic load_req_reg;
	logic snap_req_reg;
	logic alarm_reg;
	logic zero_pend_reg;
	logic osc_prev_reg;
	logic tick;
	logic match_hit;
	logic fail_pulse;
	logic [1:0] int_status_reg;
	logic [1:0] int_mask_reg;
	logic [1:0] int_event;
	rtcc_pkg::rtcc_byte_t capture_reg [0:3];
	rtcc_pkg::rtcc_byte_t match_reg [0:3];
	rtcc_pkg::rtcc_byte_t ctrl_byte;
	rtcc_pkg::rtcc_word_t capture_word;
	rtcc_pkg::rtcc_word_t match_word;
	rtcc_pkg::rtcc_word_t timer_count;
	rtcc_pkg::rtcc_word_t rd_mux;
	rtcc_pkg::rtcc_word_t prdata_reg;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign idx = PADDR[7:2];

	always_comb begin
		sel = rtcc_pkg::SEL_NONE;
		if (PADDR[1:0] == 2'b00) begin
			if (idx >= `RTCC_IDX_CAPTURE0 && idx <= `RTCC_IDX_CAPTURE3) begin
				sel = rtcc_pkg::SEL_CAPTURE;
			end else if (idx == `RTCC_IDX_CONTROL) begin
				sel = rtcc_pkg::SEL_CONTROL;
			end else if (idx >= `RTCC_IDX_ALARM0 && idx <= `RTCC_IDX_ALARM3) begin
				sel = rtcc_pkg::SEL_ALARM;
			end else if (idx == `RTCC_IDX_INT_STATUS) begin
				sel = rtcc_pkg::SEL_STATUS;
			end else if (idx == `RTCC_IDX_INT_MASK) begin
				sel = rtcc_pkg::SEL_MASK;
			end
		end
	end

	// zero wait states: write data and read data are settled by the access phase
	assign wr = PSEL && PENABLE && PWRITE;
	assign wr_ctrl = wr && (sel == rtcc_pkg::SEL_CONTROL);
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && (sel == rtcc_pkg::SEL_NONE);

	// ----------------------------------------------------------------
	// oscillator tick
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			osc_prev_reg <= 1'b0;
		end else begin
			osc_prev_reg <= RTC_OSC;
		end
	end

	// a disabled oscillator delivers no cycles, so load and snapshot stall too
	assign tick = osc_en_reg && RTC_OSC && !osc_prev_reg;

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			osc_en_reg <= 1'b0;
			mcd_en_reg <= 1'b0;
			run_reg <= 1'b0;
			aen_reg <= 1'b0;
			autorst_reg <= 1'b0;
		end else if (wr_ctrl) begin
			osc_en_reg <= PWDATA[`RTCC_CTRL_OSC_EN];
			mcd_en_reg <= PWDATA[`RTCC_CTRL_MCD_EN];
			run_reg <= PWDATA[`RTCC_CTRL_RUN];
			aen_reg <= PWDATA[`RTCC_CTRL_ALARM_EN];
			autorst_reg <= PWDATA[`RTCC_CTRL_ALARM];
		end
	end

	// hardware set wins over a same-cycle software clear
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			fail_reg <= 1'b0;
		end else if (fail_pulse) begin
			fail_reg <= 1'b1;
		end else if (wr_ctrl && !PWDATA[`RTCC_CTRL_OSC_FAIL]) begin
			fail_reg <= 1'b0;
		end
	end

	// a rewrite of 1 in the completing cycle re-arms the request
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			load_req_reg <= 1'b0;
			snap_req_reg <= 1'b0;
		end else begin
			if (wr_ctrl && PWDATA[`RTCC_CTRL_LOAD]) begin
				load_req_reg <= 1'b1;
			end else if (tick) begin
				load_req_reg <= 1'b0;
			end
			if (wr_ctrl && PWDATA[`RTCC_CTRL_SNAP]) begin
				snap_req_reg <= 1'b1;
			end else if (tick) begin
				snap_req_reg <= 1'b0;
			end
		end
	end

	assign ctrl_byte = {osc_en_reg, mcd_en_reg, fail_reg, run_reg, aen_reg, alarm_reg, load_req_reg, snap_req_reg};

	// ----------------------------------------------------------------
	// capture and alarm match bytes
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_bytes
			always_ff @(posedge CLOCK) begin
				if (RESET) begin
					capture_reg[gi] <= `RTCC_BYTE_RESET;
				end else if (snap_req_reg && tick) begin
					capture_reg[gi] <= timer_count[8*gi +: 8];
				end else if (wr && sel == rtcc_pkg::SEL_CAPTURE && idx[1:0] == 2'(gi)) begin
					capture_reg[gi] <= PWDATA[7:0];
				end
			end
			always_ff @(posedge CLOCK) begin
				if (RESET) begin
					match_reg[gi] <= `RTCC_BYTE_RESET;
				end else if (wr && sel == rtcc_pkg::SEL_ALARM && idx[1:0] == 2'(gi)) begin
					match_reg[gi] <= PWDATA[7:0];
				end
			end
		end
	endgenerate

	assign capture_word = {capture_reg[3], capture_reg[2], capture_reg[1], capture_reg[0]};
	assign match_word = {match_reg[3], match_reg[2], match_reg[1], match_reg[0]};

	// ----------------------------------------------------------------
	// timer and missing-clock detector
	// ----------------------------------------------------------------
	rtcc_timer #(
		.WIDTH(32)
	) u_timer (
		.clk(CLOCK),
		.rst(RESET),
		.tick(tick),
		.run(run_reg),
		.load(load_req_reg),
		.zero(zero_pend_reg),
		.load_value(capture_word),
		.count(timer_count)
	);

	rtcc_mcd #(
		.LIMIT(MCD_CYCLES),
		.CW(12)
	) u_mcd (
		.clk(CLOCK),
		.rst(RESET),
		.enable(mcd_en_reg),
		.osc_level(RTC_OSC),
		.fail(fail_pulse)
	);

	// ----------------------------------------------------------------
	// alarm
	// ----------------------------------------------------------------
	// compared before the same tick advances the timer
	assign match_hit = tick && aen_reg && (timer_count == match_word) && !alarm_reg;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			alarm_reg <= 1'b0;
		end else if (wr_ctrl && !PWDATA[`RTCC_CTRL_ALARM_EN]) begin
			alarm_reg <= 1'b0;
		end else if (tick) begin
			alarm_reg <= match_hit;
		end
	end

	// zero lands one oscillator cycle after the flag drops
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			zero_pend_reg <= 1'b0;
		end else if (tick) begin
			zero_pend_reg <= alarm_reg && autorst_reg;
		end
	end

	assign ALARM_EVENT = alarm_reg;
	assign OSC_ENABLE = osc_en_reg;

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign int_event[`RTCC_INT_ALARM] = match_hit;
	assign int_event[`RTCC_INT_FAIL] = fail_pulse;

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			int_status_reg <= `RTCC_INT_RESET;
		end else begin
			int_status_reg <= int_event | (int_status_reg &
				~((wr && sel == rtcc_pkg::SEL_STATUS) ? PWDATA[1:0] : 2'b00));
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			int_mask_reg <= `RTCC_INT_RESET;
		end else if (wr && sel == rtcc_pkg::SEL_MASK) begin
			int_mask_reg <= PWDATA[1:0];
		end
	end

	assign IRQ = |(int_status_reg & int_mask_reg);

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		case (sel)
			rtcc_pkg::SEL_CONTROL: rd_mux = {24'h00_0000, ctrl_byte};
			rtcc_pkg::SEL_CAPTURE: rd_mux = {24'h00_0000, capture_reg[idx[1:0]]};
			rtcc_pkg::SEL_ALARM: rd_mux = {24'h00_0000, match_reg[idx[1:0]]};
			rtcc_pkg::SEL_STATUS: rd_mux = {30'h0000_0000, int_status_reg};
			rtcc_pkg::SEL_MASK: rd_mux = {30'h0000_0000, int_mask_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// sampled in the setup cycle so PRDATA comes from a flip-flop
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			prdata_reg <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_reg <= rd_mux;
		end
	end

	assign PRDATA = prdata_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	sequence s_alarm_raised;
		match_hit && !(wr_ctrl && !PWDATA[`RTCC_CTRL_ALARM_EN]) ##1 alarm_reg;
	endsequence

	sequence s_alarm_dropped;
		tick && alarm_reg && autorst_reg ##1 !alarm_reg;
	endsequence

	a_osc_enable_write: assert property (wr_ctrl |=> OSC_ENABLE == $past(PWDATA[`RTCC_CTRL_OSC_EN]))
		else $error("oscillator enable did not follow write");
	a_mcd_enable_write: assert property (wr_ctrl |=> mcd_en_reg == $past(PWDATA[`RTCC_CTRL_MCD_EN]))
		else $error("detector enable did not follow write");
	a_fail_sticky: assert property (fail_reg && !(wr_ctrl && !PWDATA[`RTCC_CTRL_OSC_FAIL]) |=> fail_reg)
		else $error("oscillator fail flag dropped without clear");
	a_fail_set: assert property (fail_pulse |=> fail_reg)
		else $error("oscillator fail flag not set");
	a_alarm_disable_clear: assert property (wr_ctrl && !PWDATA[`RTCC_CTRL_ALARM_EN] |=> !alarm_reg && !aen_reg)
		else $error("alarm disable did not clear flag");
	a_ctrl_read_alarm: assert property (rd_setup && sel == rtcc_pkg::SEL_CONTROL
		|=> PRDATA[`RTCC_CTRL_ALARM] == $past(alarm_reg))
		else $error("control read does not show alarm flag");
	a_autoreset_write: assert property (wr_ctrl |=> autorst_reg == $past(PWDATA[`RTCC_CTRL_ALARM])
		&& (alarm_reg == $past(alarm_reg) || $past(tick) || !aen_reg)) else $error("auto-reset write misbehaved");
	a_load_done: assert property (load_req_reg && tick && !wr_ctrl |=> !load_req_reg && timer_count == $past(capture_word))
		else $error("timer load did not complete");
	a_snap_done: assert property (snap_req_reg && tick && !wr_ctrl |=> !snap_req_reg && capture_word == $past(timer_count))
		else $error("timer snapshot did not complete");
	a_alarm_one_tick: assert property (alarm_reg && tick |=> !alarm_reg)
		else $error("alarm flag outlived one oscillator cycle");
	a_alarm_cause: assert property (s_alarm_raised |-> $past(timer_count) == match_word)
		else $error("alarm raised without a match");
	a_autoreset_arm: assert property (s_alarm_dropped |-> zero_pend_reg)
		else $error("auto-reset not armed after alarm");
	a_autoreset_zero: assert property (tick && zero_pend_reg && !load_req_reg |=> timer_count == 32'h0000_0000)
		else $error("auto-reset did not zero the timer");
	a_ctrl_reset: assert property ($fell(RESET) |-> ctrl_byte[4:0] == 5'h00 && !osc_en_reg && !mcd_en_reg)
		else $error("control bits not cleared by reset");

endmodule

// ---- dv/rtcc_top_tb.sv ----
// self-checking bench for the rtc control block: apb register access, timer, alarm, detector
// assumes the shared header on the include path and rtcc_top as the design under test
`timescale 1ns/1ps
`include "rtcc_defs.svh"

module rtcc_top_tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic CLOCK;
	logic RESET;
	logic PSEL;
	logic PENABLE;
	logic PWRITE;
	logic [7:0] PADDR;
	logic [31:0] PWDATA;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic RTC_OSC;
	logic OSC_ENABLE;
	logic ALARM_EVENT;
	logic IRQ;
	int err_count;
	int total_checks;
	logic last_err;
	logic [31:0] q;
	// short detector limit keeps the stuck-level runs brief
	localparam int MCD = 20;
	localparam int CTL = `RTCC_IDX_CONTROL;
	localparam int STA = `RTCC_IDX_INT_STATUS;
	localparam int MSK = `RTCC_IDX_INT_MASK;

	rtcc_top #(.MCD_CYCLES(MCD)) uut (
		.CLOCK(CLOCK),
		.RESET(RESET),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.RTC_OSC(RTC_OSC),
		.OSC_ENABLE(OSC_ENABLE),
		.ALARM_EVENT(ALARM_EVENT),
		.IRQ(IRQ)
	);

	initial begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input int idx, input logic [31:0] d, output logic [31:0] r);
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= 8'(idx * 4);
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		// no cycle count assumed: a hang is ended by the watchdog
		do begin
			@(posedge CLOCK);
		end while (PREADY !== 1'b1);
		r = PRDATA;
		last_err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		// let the register update of this edge settle before callers look at outputs
		#1;
	endtask

	task automatic wr(input int idx, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, idx, d, r);
	endtask

	task automatic rdc(input string what, input int idx, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, idx, 32'h0000_0000, r);
		chk(what, exp, r);
	endtask

	// one oscillator cycle per step; the level stands still otherwise
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge CLOCK);
			RTC_OSC <= 1'b1;
			@(posedge CLOCK);
			RTC_OSC <= 1'b0;
		end
		@(posedge CLOCK);
		#1;
	endtask

	task automatic set_word(input int base, input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			wr(base + i, {24'h00_0000, v[8 * i +: 8]});
		end
	endtask

	task automatic snap(input logic [7:0] base, input logic [31:0] exp, input bit cmp);
		logic [31:0] r;
		logic [31:0] v;
		wr(CTL, {24'h00_0000, base | 8'h01});
		tick(1);
		rdc("ctrl after snapshot", CTL, {24'h00_0000, base & 8'hFA});
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, `RTCC_IDX_CAPTURE0 + i, 32'h0000_0000, r);
			v[8 * i +: 8] = r[7:0];
		end
		if (cmp) chk("timer snapshot", exp, v);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdc("ctrl reset", CTL, 32'h0000_0000);
		rdc("capture reset", `RTCC_IDX_CAPTURE3, 32'h0000_0000);
		rdc("alarm reset", `RTCC_IDX_ALARM0, 32'h0000_0000);
		rdc("status reset", STA, 32'h0000_0000);
		rdc("mask reset", MSK, 32'h0000_0000);
		chk("osc enable reset", 32'h0000_0000, OSC_ENABLE);
		chk("alarm reset", 32'h0000_0000, ALARM_EVENT);
		chk("irq reset", 32'h0000_0000, IRQ);
		$display("test reset done");
	endtask

	task automatic t_load_snap();
		set_word(`RTCC_IDX_CAPTURE0, 32'h1234_5678);
		wr(CTL, 32'h0000_0082);
		chk("osc enable", 32'h0000_0001, OSC_ENABLE);
		rdc("load pending", CTL, 32'h0000_0082);
		tick(1);
		rdc("load done", CTL, 32'h0000_0080);
		set_word(`RTCC_IDX_CAPTURE0, 32'h0000_0000);
		snap(8'h80, 32'h1234_5678, 1'b1);
		wr(CTL, 32'h0000_0090);
		tick(5);
		wr(CTL, 32'h0000_0080);
		tick(3);
		snap(8'h80, 32'h1234_567D, 1'b1);
		// snapshot while running must not stall the count
		wr(CTL, 32'h0000_0090);
		snap(8'h90, 32'h1234_567D, 1'b1);
		tick(2);
		wr(CTL, 32'h0000_0080);
		snap(8'h80, 32'h1234_5680, 1'b1);
		$display("test load and snapshot done");
	endtask

	task automatic t_alarm();
		set_word(`RTCC_IDX_ALARM0, 32'h1234_5683);
		wr(CTL, 32'h0000_0090);
		for (int i = 0; i < 5; i++) begin
			tick(1);
			chk("alarm while disabled", 32'h0000_0000, ALARM_EVENT);
		end
		rdc("status idle", STA, 32'h0000_0000);
		set_word(`RTCC_IDX_CAPTURE0, 32'h1234_5680);
		wr(CTL, 32'h0000_009A);
		tick(4);
		chk("alarm early", 32'h0000_0000, ALARM_EVENT);
		tick(1);
		chk("alarm on match", 32'h0000_0001, ALARM_EVENT);
		rdc("ctrl flag read", CTL, 32'h0000_009C);
		tick(1);
		chk("alarm one cycle", 32'h0000_0000, ALARM_EVENT);
		rdc("ctrl flag gone", CTL, 32'h0000_0098);
		rdc("status alarm", STA, 32'h0000_0001);
		chk("irq masked", 32'h0000_0000, IRQ);
		wr(MSK, 32'h0000_0001);
		chk("irq unmasked", 32'h0000_0001, IRQ);
		wr(STA, 32'h0000_0001);
		chk("irq cleared", 32'h0000_0000, IRQ);
		rdc("status cleared", STA, 32'h0000_0000);
		wr(CTL, 32'h0000_009A);
		tick(5);
		chk("alarm again", 32'h0000_0001, ALARM_EVENT);
		wr(CTL, 32'h0000_0090);
		#1;
		chk("alarm off clears", 32'h0000_0000, ALARM_EVENT);
		wr(STA, 32'h0000_0001);
		$display("test alarm done");
	endtask

	task automatic t_autoreset();
		wr(CTL, 32'h0000_009E);
		tick(5);
		chk("alarm autoreset", 32'h0000_0001, ALARM_EVENT);
		tick(1);
		chk("alarm drop", 32'h0000_0000, ALARM_EVENT);
		tick(1);
		wr(CTL, 32'h0000_0084);
		snap(8'h84, 32'h0000_0000, 1'b1);
		chk("irq autoreset alarm", 32'h0000_0001, IRQ);
		wr(STA, 32'h0000_0001);
		$display("test auto reset done");
	endtask

	task automatic t_mcd();
		wr(CTL, 32'h0000_0040);
		for (int i = 0; i < 10; i++) begin
			repeat (10) @(posedge CLOCK);
			RTC_OSC <= ~RTC_OSC;
		end
		rdc("no fail with edges", CTL, 32'h0000_0040);
		repeat (MCD + 10) @(posedge CLOCK);
		rdc("fail on stuck level", CTL, 32'h0000_0060);
		rdc("status fail", STA, 32'h0000_0002);
		chk("irq fail masked", 32'h0000_0000, IRQ);
		for (int i = 0; i < 5; i++) begin
			repeat (5) @(posedge CLOCK);
			RTC_OSC <= ~RTC_OSC;
		end
		rdc("fail sticky", CTL, 32'h0000_0060);
		wr(CTL, 32'h0000_0000);
		rdc("fail cleared", CTL, 32'h0000_0000);
		repeat (MCD + 20) @(posedge CLOCK);
		rdc("detector off", CTL, 32'h0000_0000);
		wr(STA, 32'h0000_0002);
		$display("test missing clock done");
	endtask

	task automatic t_unmapped();
		apb(1'b0, 12, 32'h0000_0000, q);
		chk("unmapped read", 32'h0000_0000, q);
		chk("unmapped slverr", 32'h0000_0001, last_err);
		rdc("mapped read", MSK, 32'h0000_0001);
		chk("mapped slverr", 32'h0000_0000, last_err);
		chk("pready", 32'h0000_0001, PREADY);
		$display("test unmapped done");
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		// whole run is several hundred cycles
		repeat (30000) @(posedge CLOCK);
		err_count++;
		$display("watchdog expired");
		report_and_stop();
	end

	initial begin
		err_count = 0;
		total_checks = 0;
		RESET = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0000_0000;
		RTC_OSC = 1'b0;
		repeat (5) @(posedge CLOCK);
		RESET <= 1'b0;
		t_reset();
		t_load_snap();
		t_alarm();
		t_autoreset();
		t_mcd();
		t_unmapped();
		report_and_stop();
	end
endmodule
